// file: logic/charger_mode_status_logic.sv
// Charger mode decoder, status pin and register logic
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module charger_mode_status_logic (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Comparator results
   input wire logic supply_valid,
   input wire logic supply_below_battery,
   input wire logic battery_open,
   input wire logic battery_above_short,
   input wire logic battery_above_precharge_exit,
   input wire logic battery_above_weak,
   input wire logic sys_below_battery,
   input wire logic disable_pin,
   // Fault event and kind
   input wire logic fault_event,
   input wire logic [2:0] fault_code_in,
   // Power path controls
   output logic battery_switch,
   output logic supplement_switch,
   output logic gate_drive,
   output logic battery_strong_n,
   output logic regulator_on,
   output logic linear_source_on,
   // Open-drain status pin
   output logic stat_out,
   output logic stat_oe,
   // Interrupt
   output logic irq
);
   logic rst_meta_n;
   logic rst_sync_n;
   logic [7:0] in_q;
   logic fault_q;
   logic [2:0] fault_code_q;
   logic charge_dis;
   logic stat_en;
   logic hz_mode;
   logic [2:0] fault_code;
   logic [chg_pkg::IRQ_W-1:0] irq_status;
   logic [chg_pkg::IRQ_W-1:0] irq_mask;
   chg_pkg::mode_e mode;
   logic next_charge_dis;
   logic next_stat_en;
   logic next_hz_mode;
   logic [2:0] next_fault_code;
   logic [chg_pkg::IRQ_W-1:0] next_irq_status;
   logic [chg_pkg::IRQ_W-1:0] next_irq_mask;
   logic [31:0] next_reg_rdata;
   chg_pkg::mode_e next_mode;
   logic next_battery_switch;
   logic next_supplement_switch;
   logic next_gate_drive;
   logic next_battery_strong_n;
   logic next_regulator_on;
   logic next_linear_source_on;
   logic next_stat_oe;
   logic next_irq;
   logic pulse_active;
   logic strong_change;
   logic fire;
   logic wr_ctrl;
   logic wr_mask;
   logic rd_status;
   logic v_ok, v_low, b_open, b_short, b_exit, b_weak, s_low, dis_q;

   // Reset release through two flops
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // Comparator inputs registered before decode
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         in_q <= 8'h00;
         fault_q <= 1'b0;
         fault_code_q <= 3'h0;
      end
      else
      begin
         in_q <= {disable_pin, sys_below_battery, battery_above_weak,
                  battery_above_precharge_exit, battery_above_short, battery_open,
                  supply_below_battery, supply_valid};
         fault_q <= fault_event;
         fault_code_q <= fault_code_in;
      end
   end

   assign {dis_q, s_low, b_weak, b_exit, b_short, b_open, v_low, v_ok} = in_q;

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
      addr_hit = (a == target);
   endfunction

   assign wr_ctrl = reg_write && addr_hit(reg_addr, chg_pkg::ADDR_CTRL);
   assign wr_mask = reg_write && addr_hit(reg_addr, chg_pkg::ADDR_IRQ_MASK);
   assign rd_status = reg_read && addr_hit(reg_addr, chg_pkg::ADDR_IRQ_STATUS);

   // Mode decode; sleep checked first since supply is gone
   always_comb
   begin
      next_mode = mode;
      if (!v_ok || v_low)
         next_mode = chg_pkg::MODE_SLEEP;
      else if (hz_mode || dis_q)
         next_mode = chg_pkg::MODE_HIZ;
      else if (s_low && b_short)
         next_mode = chg_pkg::MODE_SUPPLEMENT;
      else if (b_open || charge_dis)
         next_mode = chg_pkg::MODE_PWM_ONLY;
      else if (!b_short)
         next_mode = chg_pkg::MODE_LINEAR;
      else if (!b_exit)
         next_mode = chg_pkg::MODE_PRECHARGE;
      else
         next_mode = chg_pkg::MODE_FAST;
   end

   // Switch, gate and indicator per mode
   always_comb
   begin
      next_battery_switch = 1'b0;
      next_supplement_switch = 1'b0;
      next_gate_drive = 1'b1;
      next_battery_strong_n = 1'b1;
      next_regulator_on = 1'b1;
      next_linear_source_on = 1'b0;
      case (next_mode)
         chg_pkg::MODE_SLEEP, chg_pkg::MODE_OFF:
         begin
            next_battery_switch = 1'b1;
            next_supplement_switch = 1'b1;
            next_gate_drive = 1'b0;
            next_regulator_on = 1'b0;
         end
         chg_pkg::MODE_HIZ:
         begin
            // Both on only when the battery is above weak, to keep the system alive from the battery
            next_battery_switch = b_weak;
            next_supplement_switch = b_weak;
            next_gate_drive = !b_weak;
            next_regulator_on = 1'b0;
         end
         chg_pkg::MODE_SUPPLEMENT:
         begin
            next_battery_switch = !charge_dis;
            next_supplement_switch = 1'b1;
            next_gate_drive = 1'b0;
            // Indicator is don't-care; hold last value
            next_battery_strong_n = battery_strong_n;
         end
         chg_pkg::MODE_PWM_ONLY:
            next_battery_strong_n = b_open ? !b_weak : 1'b1;
         chg_pkg::MODE_LINEAR:
            next_linear_source_on = 1'b1;
         chg_pkg::MODE_PRECHARGE:
            next_linear_source_on = 1'b1;
         chg_pkg::MODE_FAST:
         begin
            next_battery_switch = 1'b1;
            next_battery_strong_n = !b_weak;
         end
         default:
            next_regulator_on = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         mode <= chg_pkg::MODE_OFF;
         battery_switch <= 1'b0;
         supplement_switch <= 1'b0;
         gate_drive <= 1'b1;
         battery_strong_n <= 1'b1;
         regulator_on <= 1'b0;
         linear_source_on <= 1'b0;
      end
      else
      begin
         mode <= next_mode;
         battery_switch <= next_battery_switch;
         supplement_switch <= next_supplement_switch;
         gate_drive <= next_gate_drive;
         battery_strong_n <= next_battery_strong_n;
         regulator_on <= next_regulator_on;
         linear_source_on <= next_linear_source_on;
      end
   end

   // Status pin pulse timer
   assign strong_change = (next_battery_strong_n != battery_strong_n);
   assign fire = fault_q || strong_change;

   stat_pulse #(
      .CYCLES(chg_pkg::FAULT_PULSE_CYC)
   ) u_stat_pulse (
      .sys_clk(sys_clk),
      .rst_sync_n(rst_sync_n),
      .fire(fire),
      .active(pulse_active)
   );

   // Pulse overrides enable; charging low only when enabled
   always_comb
   begin
      next_stat_oe = 1'b0;
      if (pulse_active || fire)
         next_stat_oe = 1'b1;
      else if (stat_en && (mode == chg_pkg::MODE_LINEAR ||
               mode == chg_pkg::MODE_PRECHARGE || mode == chg_pkg::MODE_FAST))
         next_stat_oe = 1'b1;
   end

   // Registers, interrupt status and read data
   always_comb
   begin
      next_charge_dis = charge_dis;
      next_stat_en = stat_en;
      next_hz_mode = hz_mode;
      next_irq_mask = irq_mask;
      next_fault_code = fault_code;
      next_irq_status = irq_status;
      next_reg_rdata = chg_pkg::READ_ZERO;
      if (wr_ctrl)
      begin
         next_charge_dis = reg_wdata[chg_pkg::CTRL_CHARGE_DIS];
         next_stat_en = reg_wdata[chg_pkg::CTRL_STAT_EN];
         next_hz_mode = reg_wdata[chg_pkg::CTRL_HZ_MODE];
      end
      if (wr_mask)
         next_irq_mask = reg_wdata[chg_pkg::IRQ_W-1:0];
      if (fault_q)
         next_fault_code = fault_code_q;
      if (reg_read)
      begin
         case (reg_addr)
            chg_pkg::ADDR_FAULT:
               next_reg_rdata = {29'h0, fault_code};
            chg_pkg::ADDR_CTRL:
               next_reg_rdata = {29'h0, hz_mode, stat_en, charge_dis};
            chg_pkg::ADDR_MONITOR:
               // Raw levels, no filter; hi-z values need supply_valid
               next_reg_rdata = {21'h0, mode, in_q};
            chg_pkg::ADDR_IRQ_STATUS:
               next_reg_rdata = {29'h0, irq_status};
            chg_pkg::ADDR_IRQ_MASK:
               next_reg_rdata = {29'h0, irq_mask};
            default:
               next_reg_rdata = chg_pkg::READ_ZERO;
         endcase
      end
      // Clear on read first, then new events win
      if (rd_status)
         next_irq_status = '0;
      if (fault_q)
         next_irq_status[chg_pkg::IRQ_FAULT] = 1'b1;
      if (next_mode != mode)
         next_irq_status[chg_pkg::IRQ_MODE] = 1'b1;
      if (strong_change)
         next_irq_status[chg_pkg::IRQ_STRONG] = 1'b1;
      next_irq = |(next_irq_status & next_irq_mask);
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         charge_dis <= chg_pkg::CTRL_RESET[chg_pkg::CTRL_CHARGE_DIS];
         stat_en <= chg_pkg::CTRL_RESET[chg_pkg::CTRL_STAT_EN];
         hz_mode <= chg_pkg::CTRL_RESET[chg_pkg::CTRL_HZ_MODE];
         irq_mask <= chg_pkg::IRQ_MASK_RESET;
         fault_code <= 3'h0;
         irq_status <= '0;
         reg_rdata <= chg_pkg::READ_ZERO;
         stat_oe <= 1'b0;
         stat_out <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         charge_dis <= next_charge_dis;
         stat_en <= next_stat_en;
         hz_mode <= next_hz_mode;
         irq_mask <= next_irq_mask;
         fault_code <= next_fault_code;
         irq_status <= next_irq_status;
         reg_rdata <= next_reg_rdata;
         stat_oe <= next_stat_oe;
         stat_out <= 1'b0;
         irq <= next_irq;
      end
   end
endmodule // charger_mode_status_logic

// file: logic/chg_pkg.sv
// Package of constants for the charger mode and status logic
package chg_pkg;
   // Clock and pulse timing
   localparam int CLK_HZ = 25_000_000;
   localparam int FAULT_PULSE_US = 128;
   localparam int FAULT_PULSE_CYC = (FAULT_PULSE_US * (CLK_HZ / 1_000_000) > 0) ?
      FAULT_PULSE_US * (CLK_HZ / 1_000_000) : 1;
   localparam int PULSE_CNT_W = 13;

   // Register byte addresses
   localparam logic [7:0] ADDR_FAULT = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_MONITOR = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

   // Control register fields
   localparam int CTRL_CHARGE_DIS = 0;
   localparam int CTRL_STAT_EN = 1;
   localparam int CTRL_HZ_MODE = 2;
   localparam logic [7:0] CTRL_RESET = 8'h01;

   // Fault code field width, at bits 2:0 of the fault register
   localparam int FAULT_W = 3;

   // Interrupt bit positions
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_MODE = 1;
   localparam int IRQ_STRONG = 2;
   localparam int IRQ_W = 3;

   // Reset values
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   typedef enum logic [2:0] {
      MODE_OFF,
      MODE_SLEEP,
      MODE_PWM_ONLY,
      MODE_LINEAR,
      MODE_PRECHARGE,
      MODE_FAST,
      MODE_SUPPLEMENT,
      MODE_HIZ
   } mode_e;
endpackage

// file: logic/stat_pulse.sv
// Fault pulse timer for the status pin
`timescale 1ns/1ps
module stat_pulse #(
   parameter int CYCLES = chg_pkg::FAULT_PULSE_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_sync_n,
   // Trigger and result
   input wire logic fire,
   output logic active
);
   logic [chg_pkg::PULSE_CNT_W-1:0] count;
   logic [chg_pkg::PULSE_CNT_W-1:0] next_count;

   always_comb
   begin
      next_count = count;
      if (fire)
      begin
         // Retrigger restarts the full width
         // Fire cycle already drives the pin, so load one less
         next_count = chg_pkg::PULSE_CNT_W'(CYCLES - 1);
      end
      else if (count != '0)
      begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         count <= '0;
      else
         count <= next_count;
   end

   assign active = (count != '0);
endmodule // stat_pulse

// file: sim/chg_checker.sv
// Assertion checker for the charger mode and status logic
`timescale 1ns/1ps
module chg_checker (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Watched inputs
   input wire logic reg_write,
   input wire logic supply_valid,
   input wire logic supply_below_battery,
   input wire logic battery_open,
   input wire logic battery_above_short,
   input wire logic battery_above_precharge_exit,
   input wire logic battery_above_weak,
   input wire logic sys_below_battery,
   input wire logic disable_pin,
   input wire logic fault_event,
   // Watched outputs
   input wire logic battery_switch,
   input wire logic supplement_switch,
   input wire logic gate_drive,
   input wire logic battery_strong_n,
   input wire logic stat_out,
   input wire logic stat_oe
);
   logic [2:0] up;
   logic [2:0] next_up;
   logic rdy;
   logic sleep;
   // Internal reset copy lags the pin by two flops
   assign rdy = up == 3'h7;
   assign sleep = !supply_valid || supply_below_battery;
   always_comb
   begin
      next_up = rdy ? up : up + 3'h1;
   end
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         up <= 3'h0;
      else
         up <= next_up;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   pin_never_high_a: assert property (!stat_out)
      else $error("status pin driven high");
   fault_pulse_a: assert property (rdy && fault_event |-> ##2 stat_oe [*8])
      else $error("fault pulse missing");
   strong_pulse_a: assert property (rdy && $changed(battery_strong_n) |-> ##[0:2] stat_oe)
      else $error("strong change not pulsed");
   open_weak_a: assert property ((rdy && !sleep && !disable_pin && battery_open
      && !sys_below_battery && $stable(battery_above_weak)) [*3]
      |-> battery_strong_n == !battery_above_weak) else $error("open battery strong flag");
   linear_off_a: assert property ((rdy && !sleep && !disable_pin && !battery_above_short) [*3]
      |-> !battery_switch && !supplement_switch && gate_drive) else $error("linear outputs");
   supplement_on_a: assert property ((rdy && !sleep && !disable_pin
      && sys_below_battery && battery_above_short) [*3]
      |-> supplement_switch && !gate_drive) else $error("supplement outputs");
   sleep_on_a: assert property ((rdy && sleep) [*3] |-> battery_switch && supplement_switch)
      else $error("sleep switches");
   steady_out_a: assert property ((rdy && !reg_write && $stable({supply_valid,
      supply_below_battery, battery_open, battery_above_short, battery_above_precharge_exit,
      battery_above_weak, sys_below_battery, disable_pin})) [*6]
      |-> $stable({battery_switch, supplement_switch, gate_drive})) else $error("output glitch");
endmodule // chg_checker

bind charger_mode_status_logic chg_checker u_chk (.sys_clk, .rst_n, .reg_write, .supply_valid,
   .supply_below_battery, .battery_open, .battery_above_short, .battery_above_precharge_exit,
   .battery_above_weak, .sys_below_battery, .disable_pin, .fault_event, .battery_switch,
   .supplement_switch, .gate_drive, .battery_strong_n, .stat_out, .stat_oe);

// file: sim/host_stat_model.sv
// Host-side model of the open-drain status line
`timescale 1ns/1ps
module host_stat_model (
   // Clock
   input wire logic sys_clk,
   // Status pin from the device
   input wire logic stat_out,
   input wire logic stat_oe,
   // Host view
   output logic stat_line,
   output logic [15:0] pulse_len
);
   logic [15:0] run;
   // Pull-up holds the line high when released
   assign stat_line = stat_oe ? stat_out : 1'b1;
   initial
   begin
      run = 16'h0000;
      pulse_len = 16'h0000;
   end
   always @(posedge sys_clk)
   begin
      if (!stat_line)
         run <= run + 16'h0001;
      else if (run != 16'h0000)
      begin
         pulse_len <= run;
         run <= 16'h0000;
      end
   end
endmodule // host_stat_model

// file: sim/tb_top.sv
// Testbench for the charger mode and status logic
`timescale 1ns/1ps
module tb_top;
   logic sys_clk, rst_n, reg_write, reg_read, fault_event;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic supply_valid, supply_below_battery, battery_open, battery_above_short;
   logic battery_above_precharge_exit, battery_above_weak, sys_below_battery, disable_pin;
   logic [2:0] fault_code_in;
   logic battery_switch, supplement_switch, gate_drive, battery_strong_n;
   logic stat_out, stat_oe, irq, stat_line, regulator_on, linear_source_on;
   logic [15:0] pulse_len;
   int error_cnt = 0;
   int check_count = 0;

   charger_mode_status_logic DUT (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .supply_valid, .supply_below_battery, .battery_open,
      .battery_above_short, .battery_above_precharge_exit, .battery_above_weak,
      .sys_below_battery, .disable_pin, .fault_event, .fault_code_in, .battery_switch,
      .supplement_switch, .gate_drive, .battery_strong_n, .regulator_on, .linear_source_on,
      .stat_out, .stat_oe, .irq);
   host_stat_model u_host (.sys_clk, .stat_out, .stat_oe, .stat_line, .pulse_len);

   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Hang guard, well past the longest sequence
   initial
   begin
      #600_000;
      error_cnt++;
      conclude();
   end

   initial
   begin
      {rst_n, reg_write, reg_read, fault_event, reg_addr, reg_wdata, fault_code_in} = '0;
      {supply_below_battery, battery_open, battery_above_short, disable_pin} = 4'h0;
      {battery_above_precharge_exit, battery_above_weak, sys_below_battery} = 3'h0;
      supply_valid = 1'b1;
      cyc(5);
      rst_n <= 1'b1;
      cyc(4);
      rd(chg_pkg::ADDR_CTRL, d);
      chk("ctrl reset", d, {24'h00_0000, chg_pkg::CTRL_RESET});
      rd(chg_pkg::ADDR_IRQ_MASK, d);
      chk("mask reset", d, {29'h0, chg_pkg::IRQ_MASK_RESET});
      rd(8'h40, d);
      chk("unmapped read", d, chg_pkg::READ_ZERO);
      rd(chg_pkg::ADDR_MONITOR, d);
      chk("monitor idle", d, {21'h0, chg_pkg::MODE_PWM_ONLY, 8'h01});
      wr(chg_pkg::ADDR_CTRL, 32'h0000_0000);
      cyc(4);
      rd(chg_pkg::ADDR_MONITOR, d);
      chk("monitor linear", d, {21'h0, chg_pkg::MODE_LINEAR, 8'h01});
      chk("linear pins", {28'h0, battery_switch, supplement_switch, gate_drive,
         battery_strong_n}, 32'h0000_0003);
      chk("linear sources", {30'h0, regulator_on, linear_source_on}, 32'h0000_0003);
      $display("test linear done");
      cyc(3400);
      wr(chg_pkg::ADDR_CTRL, 32'h0000_0002);
      cyc(4);
      chk("stat charging", {31'h0, stat_line}, 32'h0000_0000);
      wr(chg_pkg::ADDR_CTRL, 32'h0000_0000);
      cyc(4);
      chk("stat released", {31'h0, stat_line}, 32'h0000_0001);
      rd(chg_pkg::ADDR_IRQ_STATUS, d);
      wr(chg_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
      @(posedge sys_clk);
      fault_code_in <= 3'h5;
      fault_event <= 1'b1;
      @(posedge sys_clk);
      fault_event <= 1'b0;
      cyc(3300);
      chk("pulse length", {16'h0, pulse_len}, chg_pkg::FAULT_PULSE_CYC);
      chk("masked irq", {31'h0, irq}, 32'h0000_0000);
      rd(chg_pkg::ADDR_FAULT, d);
      chk("fault code", d, 32'h0000_0005);
      // Mask bit high lets the status bit through
      wr(chg_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
      cyc(2);
      chk("irq raised", {31'h0, irq}, 32'h0000_0001);
      rd(chg_pkg::ADDR_IRQ_STATUS, d);
      chk("irq status", d, 32'h0000_0001);
      cyc(2);
      chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
      $display("test fault done");
      @(posedge sys_clk);
      battery_open <= 1'b1;
      cyc(4);
      chk("open weak low", {31'h0, battery_strong_n}, 32'h0000_0001);
      battery_above_weak <= 1'b1;
      cyc(4);
      chk("open weak high", {31'h0, battery_strong_n}, 32'h0000_0000);
      chk("strong pulse", {31'h0, stat_line}, 32'h0000_0000);
      rd(chg_pkg::ADDR_IRQ_STATUS, d);
      chk("strong status", d, 32'h0000_0006);
      $display("test open battery done");
      @(posedge sys_clk);
      battery_open <= 1'b0;
      battery_above_short <= 1'b1;
      battery_above_precharge_exit <= 1'b1;
      sys_below_battery <= 1'b1;
      cyc(4);
      chk("supplement", {30'h0, supplement_switch, gate_drive}, 32'h0000_0002);
      supply_below_battery <= 1'b1;
      cyc(4);
      chk("sleep", {30'h0, battery_switch, supplement_switch}, 32'h0000_0003);
      chk("sleep regulator", {30'h0, regulator_on, linear_source_on}, 32'h0000_0000);
      @(posedge sys_clk);
      disable_pin <= 1'b1;
      supply_valid <= 1'b0;
      supply_below_battery <= 1'b0;
      cyc(4);
      // Supply invalid, so the host trusts only the supply flag
      rd(chg_pkg::ADDR_MONITOR, d);
      chk("hi-z supply flag", {31'h0, d[0]}, 32'h0000_0000);
      $display("test power path done");
      conclude();
   end
endmodule // tb_top
